// >>> rmai_pkg.sv
// Package: register map, field positions and reset values of the alarm and interrupt block
package rmai_pkg;
   localparam int             ADDR_W            = 16;
   localparam int             DATA_W            = 8;
   localparam int             LIMIT_W           = 17;
   localparam int             NUM_REFS          = 2;
   localparam int             GP_W              = 4;
   localparam logic [15:0]    MAIN_LIMIT_HI_ADDR = 16'h0071;
   localparam logic [15:0]    MAIN_LIMIT_MID_ADDR = 16'h0072;
   localparam logic [15:0]    MAIN_LIMIT_LO_ADDR = 16'h0073;
   localparam logic [15:0]    FB_LIMIT_HI_ADDR  = 16'h0074;
   localparam logic [15:0]    FB_LIMIT_MID_ADDR = 16'h0075;
   localparam logic [15:0]    FB_LIMIT_LO_ADDR  = 16'h0076;
   localparam logic [15:0]    IRQ_ENABLE_ADDR   = 16'h0079;
   localparam logic [15:0]    FACTORY_ADDR      = 16'h007a;
   localparam logic [15:0]    STICKY_STATUS_ADDR = 16'h0200;
   localparam logic [15:0]    GP_INPUT_ADDR     = 16'h020c;
   localparam logic [15:0]    IRQ_SUMMARY_ADDR  = 16'h020d;
   localparam int             UNLOCK_BIT        = 6;
   localparam int             MAIN_MISS_BIT     = 0;
   localparam int             FB_MISS_BIT       = 1;
   localparam int             SUMMARY_BIT       = 0;
   localparam logic [16:0]    LIMIT_RESET       = 17'h000b1;
   localparam logic [7:0]     IRQ_ENABLE_RESET  = 8'h00;
   localparam logic [7:0]     STATUS_RESET      = 8'h00;
   localparam logic [7:0]     FACTORY_RESET     = 8'h27;
   localparam logic [16:0]    LIMIT_MIN         = 17'h00003;
endpackage

// >>> rmai_miss_counter.sv
// One reference-missing timeout counter with a three-stage edge synchroniser
`timescale 1ns/1ps
`default_nettype none
module rmai_miss_counter #(
   parameter int LIMIT_W = 17
) (
   input  wire logic               clk_sys_in,
   input  wire logic               rst_in,
   input  wire logic               ref_in,
   input  wire logic               ref_enable_in,
   input  wire logic [LIMIT_W-1:0] limit_in,
   output logic                    missing_out
);
   logic [2:0]         sync_r;
   logic [LIMIT_W-1:0] count_r;
   logic [LIMIT_W-1:0] count_nxt;
   logic               missing_nxt;
   wire                ref_edge;
   wire                at_limit;

   // ==========================================================
   // Rising-edge detect on the two late stages only
   assign ref_edge  = sync_r[1] & ~sync_r[2];
   assign at_limit  = (count_r + LIMIT_W'(1)) >= limit_in;

   always_comb
   begin
      count_nxt   = count_r;
      missing_nxt = missing_out;
      if (!ref_enable_in || ref_edge)
      begin
         count_nxt   = '0;
         missing_nxt = 1'b0;
      end
      else if (at_limit)
      begin
         missing_nxt = 1'b1;
      end
      else
      begin
         count_nxt = count_r + LIMIT_W'(1);
      end
   end

   always_ff @(posedge clk_sys_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         sync_r      <= 3'h0;
         count_r     <= '0;
         missing_out <= 1'b0;
      end
      else
      begin
         sync_r      <= {sync_r[1:0], ref_in};
         count_r     <= count_nxt;
         missing_out <= missing_nxt;
      end
   end
endmodule
`default_nettype wire

// >>> rmai_top.sv
// Top: reference-missing monitors, sticky alarm flags, interrupt pin and register port
`timescale 1ns/1ps
`default_nettype none
module rmai_top
   import rmai_pkg::*;
#(
   parameter int LIMIT_WIDTH = rmai_pkg::LIMIT_W
) (
   input  wire logic                          clk_sys_in,
   input  wire logic                          rst_in,
   input  wire logic                          reg_wr_in,
   input  wire logic                          reg_rd_in,
   input  wire logic [rmai_pkg::ADDR_W-1:0]   reg_addr_in,
   input  wire logic [rmai_pkg::DATA_W-1:0]   reg_wdata_in,
   output logic      [rmai_pkg::DATA_W-1:0]   reg_rdata_out,
   input  wire logic                          main_ref_in,
   input  wire logic                          feedback_ref_in,
   input  wire logic [rmai_pkg::NUM_REFS-1:0] ref_enable_in,
   input  wire logic                          unlock_alarm_in,
   input  wire logic [rmai_pkg::GP_W-1:0]     gp_pin_in,
   input  wire logic [rmai_pkg::GP_W-1:0]     gp_is_input_in,
   output logic                               irq_pin_n_out,
   output logic                               irq_pin_n_oe_out
);
   import rmai_pkg::*;

   // ==========================================================
   // Registers
   logic [LIMIT_WIDTH-1:0] ref_missing_limit_r [NUM_REFS];
   logic [DATA_W-1:0]      alarm_irq_enable_r;
   logic [DATA_W-1:0]      alarm_sticky_status_r;
   logic [DATA_W-1:0]      alarm_sticky_status_nxt;
   logic [GP_W-1:0]        gp_s1_r;
   logic [GP_W-1:0]        gp_s2_r;
   logic [GP_W-1:0]        gp_s3_r;
   logic [GP_W-1:0]        gp_input_state_r;
   logic [2:0]             unlock_sync_r;
   logic                   unlock_prev_r;
   logic [DATA_W-1:0]      rdata_nxt;

   wire  [NUM_REFS-1:0]    ref_pins;
   wire  [NUM_REFS-1:0]    ref_missing_alarm;
   logic [NUM_REFS-1:0]    ref_missing_prev_r;
   wire  [DATA_W-1:0]      alarm_events;
   wire  [DATA_W-1:0]      clear_mask;
   wire  [DATA_W-1:0]      enabled_flags;
   wire                    irq_active;
   wire                    unlock_rise;
   wire                    wr_enable;
   wire                    wr_status;
   wire  [DATA_W-1:0]      summary_byte;

   // ==========================================================
   // Monitor channels
   assign ref_pins = {feedback_ref_in, main_ref_in};

   genvar gi;
   generate
      for (gi = 0; gi < NUM_REFS; gi++)
      begin : g_mon
         rmai_miss_counter #(
            .LIMIT_W (LIMIT_WIDTH)
         ) u_miss (
            .clk_sys_in    (clk_sys_in),
            .rst_in        (rst_in),
            .ref_in        (ref_pins[gi]),
            .ref_enable_in (ref_enable_in[gi]),
            .limit_in      (ref_missing_limit_r[gi]),
            .missing_out   (ref_missing_alarm[gi])
         );
      end
   endgenerate

   // ==========================================================
   // Alarm events and sticky flags
   assign unlock_rise = unlock_sync_r[1] & unlock_sync_r[2] & ~unlock_prev_r;

   // Flags set on rising alarm, independent of the interrupt enables
   assign alarm_events = {1'b0, unlock_rise, 4'h0,
                          ref_missing_alarm & ~ref_missing_prev_r};

   assign wr_status = reg_wr_in && (reg_addr_in == STICKY_STATUS_ADDR);
   assign wr_enable = reg_wr_in && (reg_addr_in == IRQ_ENABLE_ADDR);
   assign clear_mask = wr_status ? reg_wdata_in : 8'h00;

   // Set wins over a clear in the same cycle
   always_comb
   begin
      alarm_sticky_status_nxt = (alarm_sticky_status_r & ~clear_mask)
                              | alarm_events;
      alarm_sticky_status_nxt[7] = 1'b0;
      alarm_sticky_status_nxt[5:2] = 4'h0;
   end

   // ==========================================================
   // Interrupt summary
   assign enabled_flags = alarm_sticky_status_r & alarm_irq_enable_r;
   assign irq_active    = |enabled_flags;
   assign summary_byte  = {7'h00, irq_active};

   // ==========================================================
   // Read mux
   always_comb
   begin
      case (reg_addr_in)
         MAIN_LIMIT_HI_ADDR:  rdata_nxt = {7'h00, ref_missing_limit_r[0][16]};
         MAIN_LIMIT_MID_ADDR: rdata_nxt = ref_missing_limit_r[0][15:8];
         MAIN_LIMIT_LO_ADDR:  rdata_nxt = ref_missing_limit_r[0][7:0];
         FB_LIMIT_HI_ADDR:    rdata_nxt = {7'h00, ref_missing_limit_r[1][16]};
         FB_LIMIT_MID_ADDR:   rdata_nxt = ref_missing_limit_r[1][15:8];
         FB_LIMIT_LO_ADDR:    rdata_nxt = ref_missing_limit_r[1][7:0];
         IRQ_ENABLE_ADDR:     rdata_nxt = alarm_irq_enable_r;
         FACTORY_ADDR:        rdata_nxt = FACTORY_RESET;
         STICKY_STATUS_ADDR:  rdata_nxt = alarm_sticky_status_r;
         GP_INPUT_ADDR:       rdata_nxt = {4'h0, gp_input_state_r};
         IRQ_SUMMARY_ADDR:    rdata_nxt = summary_byte;
         default:             rdata_nxt = 8'h00;
      endcase
   end

   // ==========================================================
   // Limit registers, one per channel
   generate
      for (gi = 0; gi < NUM_REFS; gi++)
      begin : g_lim
         wire [15:0] hi_a;
         wire [15:0] mid_a;
         wire [15:0] lo_a;
         assign hi_a  = (gi == 0) ? MAIN_LIMIT_HI_ADDR  : FB_LIMIT_HI_ADDR;
         assign mid_a = (gi == 0) ? MAIN_LIMIT_MID_ADDR : FB_LIMIT_MID_ADDR;
         assign lo_a  = (gi == 0) ? MAIN_LIMIT_LO_ADDR  : FB_LIMIT_LO_ADDR;
         always_ff @(posedge clk_sys_in or posedge rst_in)
         begin
            if (rst_in)
               ref_missing_limit_r[gi] <= LIMIT_RESET;
            else if (reg_wr_in && reg_addr_in == hi_a)
               ref_missing_limit_r[gi][16] <= reg_wdata_in[0];
            else if (reg_wr_in && reg_addr_in == mid_a)
               ref_missing_limit_r[gi][15:8] <= reg_wdata_in;
            else if (reg_wr_in && reg_addr_in == lo_a)
               ref_missing_limit_r[gi][7:0] <= reg_wdata_in;
         end
      end
   endgenerate

   // ==========================================================
   // Enable, status and pin-side flops
   always_ff @(posedge clk_sys_in or posedge rst_in)
   begin
      if (rst_in)
         alarm_irq_enable_r <= IRQ_ENABLE_RESET;
      else if (wr_enable)
         alarm_irq_enable_r <= {1'b0, reg_wdata_in[UNLOCK_BIT], 4'h0,
                                reg_wdata_in[FB_MISS_BIT],
                                reg_wdata_in[MAIN_MISS_BIT]};
   end

   always_ff @(posedge clk_sys_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         alarm_sticky_status_r <= STATUS_RESET;
         ref_missing_prev_r    <= '0;
         unlock_sync_r         <= 3'h0;
         unlock_prev_r         <= 1'b0;
      end
      else
      begin
         alarm_sticky_status_r <= alarm_sticky_status_nxt;
         ref_missing_prev_r    <= ref_missing_alarm;
         unlock_sync_r         <= {unlock_sync_r[1:0], unlock_alarm_in};
         unlock_prev_r         <= unlock_sync_r[1] & unlock_sync_r[2];
      end
   end

   always_ff @(posedge clk_sys_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         gp_s1_r          <= '0;
         gp_s2_r          <= '0;
         gp_s3_r          <= '0;
         gp_input_state_r <= '0;
         irq_pin_n_out    <= 1'b0;
         irq_pin_n_oe_out <= 1'b0;
         reg_rdata_out    <= 8'h00;
      end
      else
      begin
         gp_s1_r <= gp_pin_in;
         gp_s2_r <= gp_s1_r;
         gp_s3_r <= gp_s2_r;
         gp_input_state_r <= ((gp_s2_r & gp_s3_r) | (gp_input_state_r & (gp_s2_r | gp_s3_r)))
                             & gp_is_input_in;
         irq_pin_n_out    <= 1'b0;
         irq_pin_n_oe_out <= irq_active;
         if (reg_rd_in)
            reg_rdata_out <= rdata_nxt;
      end
   end
endmodule
`default_nettype wire

// >>> rmai_properties.sv
// Checker: port-level properties of the alarm and interrupt block
`timescale 1ns/1ps
`default_nettype none
module rmai_checker #(
   parameter int LIMIT_WIDTH = 17
) (
   input wire logic                        clk_sys_in,
   input wire logic                        rst_in,
   input wire logic                        reg_wr_in,
   input wire logic                        reg_rd_in,
   input wire logic [rmai_pkg::ADDR_W-1:0] reg_addr_in,
   input wire logic [rmai_pkg::DATA_W-1:0] reg_wdata_in,
   input wire logic [rmai_pkg::DATA_W-1:0] reg_rdata_out,
   input wire logic                        unlock_alarm_in,
   input wire logic                        irq_pin_n_out,
   input wire logic                        irq_pin_n_oe_out
);
   import rmai_pkg::*;
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (rst_in);
   // ========================================
   // Shadow of the enable register
   logic [7:0] en_r;
   always_ff @(posedge clk_sys_in or posedge rst_in)
      if (rst_in)
         en_r <= 8'h00;
      else if (reg_wr_in && reg_addr_in == IRQ_ENABLE_ADDR)
         en_r <= reg_wdata_in & 8'h43;
   // ========================================
   // Properties
   pin_data_low_a: assert property (!irq_pin_n_out)
      else $error("pin data not low");
   disabled_quiet_a: assert property ($past(en_r) == 8'h00 |-> !irq_pin_n_oe_out)
      else $error("pin asserted with enables off");
   unlock_raises_a: assert property ($rose(unlock_alarm_in) && en_r[6] |-> ##[1:8] irq_pin_n_oe_out)
      else $error("enabled unlock did not assert pin");
   gp_upper_zero_a: assert property (reg_rd_in && reg_addr_in == GP_INPUT_ADDR |=> reg_rdata_out[7:4] == 4'h0)
      else $error("input levels upper bits set");
   enable_readback_a: assert property (reg_rd_in && reg_addr_in == IRQ_ENABLE_ADDR |=> reg_rdata_out == $past(en_r))
      else $error("enable readback wrong");
   summary_match_a: assert property (reg_rd_in && reg_addr_in == IRQ_SUMMARY_ADDR |=> reg_rdata_out == {7'h00, irq_pin_n_oe_out})
      else $error("summary bit disagrees with pin");
   status_rsvd_a: assert property (reg_rd_in && reg_addr_in == STICKY_STATUS_ADDR |=> (reg_rdata_out & 8'hbc) == 8'h00)
      else $error("status reserved bits set");
   oe_fall_cause_a: assert property ($fell(irq_pin_n_oe_out) |-> $past(reg_wr_in, 2))
      else $error("pin released without a write");
   cover property ($rose(irq_pin_n_oe_out));
   cover property (reg_wr_in && reg_addr_in == STICKY_STATUS_ADDR);
   cover property (reg_rd_in && reg_addr_in == IRQ_SUMMARY_ADDR);
endmodule
bind rmai_top rmai_checker #(.LIMIT_WIDTH(LIMIT_WIDTH)) rmai_checker_i (
   .clk_sys_in(clk_sys_in), .rst_in(rst_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
   .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
   .unlock_alarm_in(unlock_alarm_in), .irq_pin_n_out(irq_pin_n_out),
   .irq_pin_n_oe_out(irq_pin_n_oe_out));
`default_nettype wire

// >>> rmai_host.sv
// Partner: register host issuing accesses on falling edges
`timescale 1ns/1ps
`default_nettype none
module rmai_host (
   input  wire logic                        clk_sys_in,
   output logic                             reg_wr_out,
   output logic                             reg_rd_out,
   output logic [rmai_pkg::ADDR_W-1:0]      reg_addr_out,
   output logic [rmai_pkg::DATA_W-1:0]      reg_wdata_out,
   input  wire logic [rmai_pkg::DATA_W-1:0] reg_rdata_in
);
   import rmai_pkg::*;
   initial {reg_wr_out, reg_rd_out, reg_addr_out, reg_wdata_out} = '0;
   // ========================================
   // Bus cycles, reserved bits sent as zero only for the enable and status registers
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(negedge clk_sys_in);
      reg_addr_out <= a;
      reg_wdata_out <= (a == IRQ_ENABLE_ADDR || a == STICKY_STATUS_ADDR) ? d & 8'h43 : d;
      reg_wr_out <= 1'b1;
      @(negedge clk_sys_in);
      reg_wr_out <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      @(negedge clk_sys_in);
      reg_addr_out <= a;
      reg_rd_out <= 1'b1;
      @(negedge clk_sys_in);
      reg_rd_out <= 1'b0;
      d = reg_rdata_in;
   endtask
endmodule
`default_nettype wire

// >>> tb_top.sv
// Testbench: register-level tests of the alarm and interrupt block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import rmai_pkg::*;
   logic              clk_sys_in = 1'b0;
   logic              rst_in = 1'b1;
   logic              wr, rd, pin_n, pin_oe;
   logic              main_ref = 1'b0;
   logic              fb_ref = 1'b0;
   logic              unlock = 1'b0;
   logic [1:0]        run = 2'b11;
   logic [GP_W-1:0]   gp_pin = 4'hb;
   logic [GP_W-1:0]   gp_dir = 4'h6;
   logic [1:0]        ref_en = 2'b11;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata, rdata, seen;
   int                fails = 0;
   int                tests_run = 0;
   initial forever #12.5 clk_sys_in = ~clk_sys_in;
   // ========================================
   // Reference sources, held low while stopped
   always
   begin
      repeat (4) @(negedge clk_sys_in);
      main_ref <= run[0] & ~main_ref;
      repeat (3) @(negedge clk_sys_in);
      fb_ref <= run[1] & ~fb_ref;
   end
   rmai_host rmai_host_i (.clk_sys_in(clk_sys_in), .reg_wr_out(wr), .reg_rd_out(rd),
      .reg_addr_out(addr), .reg_wdata_out(wdata), .reg_rdata_in(rdata));
   rmai_top rmai_top_i (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .reg_wr_in(wr),
      .reg_rd_in(rd), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
      .main_ref_in(main_ref), .feedback_ref_in(fb_ref), .ref_enable_in(ref_en),
      .unlock_alarm_in(unlock), .gp_pin_in(gp_pin), .gp_is_input_in(gp_dir),
      .irq_pin_n_out(pin_n), .irq_pin_n_oe_out(pin_oe));
   // ========================================
   // Helpers
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         fails++;
         $display("[ERR] %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
      rmai_host_i.rd(a, seen);
      chk(seen, exp);
   endtask
   task automatic pulse_unlock;
      unlock = 1'b1;
      repeat (5) @(negedge clk_sys_in);
      unlock = 1'b0;
      repeat (6) @(negedge clk_sys_in);
   endtask
   task automatic summarize;
      $display("Checks %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial
   begin
      #500000;
      fails++;
      summarize;
   end
   // ========================================
   // Test sequence
   initial
   begin
      repeat (8) @(negedge clk_sys_in);
      rst_in = 1'b0;
      rd_chk(MAIN_LIMIT_LO_ADDR, 8'hb1);
      rd_chk(FB_LIMIT_LO_ADDR, 8'hb1);
      rd_chk(IRQ_ENABLE_ADDR, 8'h00);
      rd_chk(STICKY_STATUS_ADDR, 8'h00);
      rd_chk(16'h0077, 8'h00);
      rd_chk(GP_INPUT_ADDR, 8'h02);
      gp_pin = 4'h4;
      repeat (5) @(negedge clk_sys_in);
      rd_chk(GP_INPUT_ADDR, 8'h04);
      gp_dir = 4'h3;
      rd_chk(GP_INPUT_ADDR, 8'h00);
      rmai_host_i.wr(MAIN_LIMIT_LO_ADDR, 8'h20);
      rmai_host_i.wr(FB_LIMIT_LO_ADDR, 8'h20);
      rd_chk(FB_LIMIT_LO_ADDR, 8'h20);
      repeat (100) @(negedge clk_sys_in);
      rd_chk(STICKY_STATUS_ADDR, 8'h00);
      ref_en = 2'b10;
      run[0] = 1'b0;
      repeat (60) @(negedge clk_sys_in);
      rd_chk(STICKY_STATUS_ADDR, 8'h00);
      ref_en = 2'b11;
      run[0] = 1'b1;
      for (int ch = 0; ch < 2; ch++)
      begin
         run[ch] = 1'b0;
         repeat (6) @(negedge clk_sys_in);
         rd_chk(STICKY_STATUS_ADDR, 8'h00);
         repeat (50) @(negedge clk_sys_in);
         rd_chk(STICKY_STATUS_ADDR, 8'h01 << ch);
         chk({7'h00, pin_oe}, 8'h00);
         rmai_host_i.wr(IRQ_ENABLE_ADDR, 8'h01 << ch);
         run[ch] = 1'b1;
         rd_chk(STICKY_STATUS_ADDR, 8'h01 << ch);
         chk({7'h00, pin_oe}, 8'h01);
         rmai_host_i.wr(STICKY_STATUS_ADDR, 8'h00);
         rd_chk(STICKY_STATUS_ADDR, 8'h01 << ch);
         rmai_host_i.wr(STICKY_STATUS_ADDR, 8'h01 << ch);
         rd_chk(STICKY_STATUS_ADDR, 8'h00);
         chk({7'h00, pin_oe}, 8'h00);
      end
      pulse_unlock;
      rd_chk(STICKY_STATUS_ADDR, 8'h40);
      chk({7'h00, pin_oe}, 8'h00);
      rmai_host_i.wr(IRQ_ENABLE_ADDR, 8'h43);
      rd_chk(IRQ_ENABLE_ADDR, 8'h43);
      rd_chk(IRQ_SUMMARY_ADDR, 8'h01);
      rmai_host_i.wr(STICKY_STATUS_ADDR, 8'h40);
      rd_chk(IRQ_SUMMARY_ADDR, 8'h00);
      pulse_unlock;
      chk({7'h00, pin_oe}, 8'h01);
      chk({7'h00, pin_n}, 8'h00);
      summarize;
   end
endmodule
`default_nettype wire
